// ---- mbdw_defines.svh ----
// Purpose: constants of the double-word parameter write interpreter
// Assumes: parameter address is group * 100 + index
// Notes: definitions only
`ifndef MBDW_DEFINES_SVH
`define MBDW_DEFINES_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define MBDW_FC_WRITE_WORD 8'h06
`define MBDW_FC_WRITE_DWORD 8'h10
`define MBDW_LEN_WORD 4'h8
`define MBDW_LEN_DWORD 4'hd
`define MBDW_REG_COUNT 16'h0002
`define MBDW_BYTE_COUNT 8'h04
`define MBDW_REPLY_HDR 3'h6
`define MBDW_CRC_INIT 16'hffff
`define MBDW_CRC_POLY 16'ha001

// ****************************************************************
// parameter addresses (group * stride + index)
// ****************************************************************
`define MBDW_GROUP_STRIDE 100
`define MBDW_GROUP_MOTOR 0
`define MBDW_ADDR_FIRST 16'h0001
`define MBDW_NUM_PARAMS 6

// ****************************************************************
// reset values and upper limits
// ****************************************************************
`define MBDW_RST_RATED_CURRENT 16'h003c
`define MBDW_RST_RATED_SPEED 16'h0bb8
`define MBDW_RST_MAX_SPEED 16'h0bb8
`define MBDW_RST_DIRECTION 16'h0001
`define MBDW_RST_POLE_PAIRS 16'h0004
`define MBDW_RST_MOTOR_TYPE 16'h0000
`define MBDW_MAX_WORD 16'h7fff
`define MBDW_MAX_DIRECTION 16'h0001

`endif

// ---- mbdw_pkg.sv ----
// Purpose: types of the double-word parameter write interpreter
// Assumes: constants come from mbdw_defines.svh
// Notes: no timing here
package mbdw_pkg;

	// byte stream carrier
	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
	} mbdw_byte_s;

	// parameters as seen by the drive
	typedef struct packed
	{
		logic [15:0] motor_rated_current;
		logic [15:0] motor_rated_speed;
		logic [15:0] motor_max_speed;
		logic [15:0] rotation_direction_select;
		logic [15:0] motor_pole_pairs;
		logic [15:0] motor_type_select;
	} mbdw_params_s;

	// when a parameter may be written
	typedef enum logic [1:0]
	{
		MBDW_SET_STOP = 2'h0,
		MBDW_SET_ZERO = 2'h1,
		MBDW_SET_ANY = 2'h2
	} mbdw_set_e;

	// when a new value is used
	typedef enum logic
	{
		MBDW_EFF_NOW = 1'h0,
		MBDW_EFF_RESET = 1'h1
	} mbdw_eff_e;

	// interpreter states, one-hot
	typedef enum logic [2:0]
	{
		MBDW_ST_RX = 3'h1,
		MBDW_ST_EXEC = 3'h2,
		MBDW_ST_TX = 3'h4
	} mbdw_state_e;

endpackage

// ---- mbdw_writer.sv ----
// Purpose: slave-side interpreter for single and double word writes
// Assumes: bytes arrive framed; frame_end_i marks the end of a frame
// Notes: refused or corrupt frames get no reply
`include "mbdw_defines.svh"
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - parameter group xx index yy sits at address xx*100+yy.
// - double write uses count 2, byte count 4, words high byte first.
// - frames end in CRC16, low byte first.
// - success reply: address, 0x10, start, count, new CRC, no data.
// - word order of the two data words follows a setting.
// - stop-to-set parameters are writable only while drive disabled.
// - zero-speed parameters are writable only at zero speed.
// - immediate parameters take effect as soon as written.
// - reset-effective parameters are used only after drive reset.
// - anytime parameters are writable at any time after power-on.
// - rated current 0..32767 tenths, default 60, password, stop-to-set.
// - rated and max speed 1..32767, default 3000, stop-to-set.
// - direction 0 or 1, default 1; 1 is counterclockwise.
// - direction change blocks running until encoder relearned.
// - pole pairs 1..32767, default 4, stop-to-set.
// - single word write 0x06 echoes the request unchanged.
module mbdw_writer
#(
	parameter int NUM_PARAMS = `MBDW_NUM_PARAMS
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire mbdw_pkg::mbdw_byte_s rx_i,
	input wire logic frame_end_i,
	input wire logic [7:0] slave_addr_i,
	input wire logic word_order_select_i,
	input wire logic drive_enabled_i,
	input wire logic zero_speed_i,
	input wire logic password_ok_i,
	input wire logic drive_reset_i,
	input wire logic encoder_learned_i,
	input wire logic tx_ready_i,
	output mbdw_pkg::mbdw_byte_s tx_o,
	output mbdw_pkg::mbdw_params_s params_o,
	output logic run_inhibit_o
);

	// ************************************************************
	// functions
	// ************************************************************

	// one byte of the reflected crc16
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ `MBDW_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// write window of each parameter
	function automatic mbdw_pkg::mbdw_set_e set_class(input logic [2:0] i);
		set_class = mbdw_pkg::MBDW_SET_STOP;
	endfunction

	// effect moment of each parameter
	function automatic mbdw_pkg::mbdw_eff_e eff_class(input logic [2:0] i);
		eff_class = mbdw_pkg::MBDW_EFF_NOW;
	endfunction

	// legal value range of each parameter
	function automatic logic in_range(input logic [2:0] i,
		input logic [31:0] v);
		logic [15:0] lo;
		logic [15:0] hi;
		lo = 16'h0000;
		hi = `MBDW_MAX_WORD;
		case (i)
			3'h1, 3'h2, 3'h4: lo = 16'h0001;
			3'h3: hi = `MBDW_MAX_DIRECTION;
			default: lo = 16'h0000;
		endcase
		in_range = (v[31:16] == 16'h0000) && (v[15:0] >= lo)
			&& (v[15:0] <= hi);
	endfunction

	// ************************************************************
	// receive side
	// ************************************************************

	mbdw_pkg::mbdw_state_e state;
	mbdw_pkg::mbdw_state_e next_state;
	logic [7:0] rx_buf [13];
	logic [3:0] rx_cnt;
	logic rx_over;
	logic [15:0] rx_crc;
	logic [15:0] bank [NUM_PARAMS];
	logic [15:0] active [NUM_PARAMS];
	logic [2:0] tx_idx;
	logic [15:0] tx_crc;

	wire rx_take = rx_i.valid && (state == mbdw_pkg::MBDW_ST_RX);
	wire rx_full = (rx_cnt == `MBDW_LEN_DWORD);

	// bytes beyond the longest frame mark the frame as overrun
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rx_cnt <= 4'h0;
			rx_over <= 1'b0;
			rx_crc <= `MBDW_CRC_INIT;
		end
		else if (state != mbdw_pkg::MBDW_ST_RX || frame_end_i)
		begin
			rx_cnt <= 4'h0;
			rx_over <= 1'b0;
			rx_crc <= `MBDW_CRC_INIT;
		end
		else if (rx_take)
		begin
			rx_over <= rx_over | rx_full;
			rx_cnt <= rx_full ? rx_cnt : rx_cnt + 4'h1;
			rx_crc <= crc_step(rx_crc, rx_i.data);
		end
	end

	// data storage needs no reset
	always_ff @(posedge clk_i)
	begin
		if (rx_take && !rx_full)
		begin
			rx_buf[rx_cnt] <= rx_i.data;
		end
	end

	// ************************************************************
	// frame decode
	// ************************************************************

	// length and crc are latched at frame end, checked in exec
	logic [3:0] fr_len;
	logic fr_crc_ok;
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			fr_len <= 4'h0;
			fr_crc_ok <= 1'b0;
		end
		else if (rx_take || frame_end_i)
		begin
			fr_len <= rx_over ? 4'h0 : rx_cnt + {3'h0, rx_take};
			fr_crc_ok <= (rx_take ? crc_step(rx_crc, rx_i.data) : rx_crc)
				== 16'h0000;
		end
	end

	wire [15:0] reg_addr = {rx_buf[2], rx_buf[3]};
	wire [15:0] reg_cnt = {rx_buf[4], rx_buf[5]};
	wire [15:0] base_addr = 16'(`MBDW_GROUP_MOTOR * `MBDW_GROUP_STRIDE);
	wire [15:0] rel_addr = reg_addr - base_addr - `MBDW_ADDR_FIRST;
	wire addr_hit = (reg_addr >= base_addr + `MBDW_ADDR_FIRST)
		&& (rel_addr < 16'(NUM_PARAMS));
	wire [2:0] widx = rel_addr[2:0];
	wire is_word = (fr_len == `MBDW_LEN_WORD)
		&& (rx_buf[1] == `MBDW_FC_WRITE_WORD);
	wire is_dword = (fr_len == `MBDW_LEN_DWORD)
		&& (rx_buf[1] == `MBDW_FC_WRITE_DWORD)
		&& (reg_cnt == `MBDW_REG_COUNT)
		&& (rx_buf[6] == `MBDW_BYTE_COUNT);
	// word order: 0 takes the first word as high, 1 as low
	wire [31:0] dw_val = word_order_select_i
		? {rx_buf[9], rx_buf[10], rx_buf[7], rx_buf[8]}
		: {rx_buf[7], rx_buf[8], rx_buf[9], rx_buf[10]};
	wire [31:0] wr_val = is_dword ? dw_val
		: {16'h0000, rx_buf[4], rx_buf[5]};
	wire mbdw_pkg::mbdw_set_e wcls = set_class(widx);
	wire set_ok = (wcls == mbdw_pkg::MBDW_SET_ANY)
		|| (wcls == mbdw_pkg::MBDW_SET_ZERO && zero_speed_i)
		|| (wcls == mbdw_pkg::MBDW_SET_STOP && !drive_enabled_i);
	wire pw_ok = (widx != 3'h0) || password_ok_i;
	wire frame_ok = fr_crc_ok && (rx_buf[0] == slave_addr_i)
		&& (is_word || is_dword) && addr_hit
		&& set_ok && pw_ok && in_range(widx, wr_val);
	wire in_exec = (state == mbdw_pkg::MBDW_ST_EXEC);
	wire do_write = in_exec && frame_ok;

	// ************************************************************
	// state machine
	// ************************************************************

	wire tx_fire = tx_o.valid && tx_ready_i;
	always_comb
	begin
		next_state = state;
		case (state)
			mbdw_pkg::MBDW_ST_RX:
				if (frame_end_i)
					next_state = mbdw_pkg::MBDW_ST_EXEC;
			mbdw_pkg::MBDW_ST_EXEC:
				next_state = frame_ok ? mbdw_pkg::MBDW_ST_TX
					: mbdw_pkg::MBDW_ST_RX;
			mbdw_pkg::MBDW_ST_TX:
				if (tx_fire && tx_idx == 3'h7)
					next_state = mbdw_pkg::MBDW_ST_RX;
			default:
				next_state = mbdw_pkg::MBDW_ST_RX;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			state <= mbdw_pkg::MBDW_ST_RX;
		else
			state <= next_state;
	end

	// ************************************************************
	// parameter bank
	// ************************************************************

	localparam logic [15:0] RST_VAL [6] = '{`MBDW_RST_RATED_CURRENT,
		`MBDW_RST_RATED_SPEED, `MBDW_RST_MAX_SPEED, `MBDW_RST_DIRECTION,
		`MBDW_RST_POLE_PAIRS, `MBDW_RST_MOTOR_TYPE};

	// stored copy takes the write; the used copy waits for its moment
	for (genvar g = 0; g < NUM_PARAMS; g++)
	begin : g_param
		wire hit = do_write && (widx == 3'(g));
		wire use_now = (eff_class(3'(g)) == mbdw_pkg::MBDW_EFF_NOW);
		always_ff @(posedge clk_i or negedge rst_b_i)
		begin
			if (!rst_b_i)
			begin
				bank[g] <= RST_VAL[g];
				active[g] <= RST_VAL[g];
			end
			else
			begin
				if (hit)
					bank[g] <= wr_val[15:0];
				if (use_now && hit)
					active[g] <= wr_val[15:0];
				else if (drive_reset_i)
					active[g] <= bank[g];
			end
		end
	end

	// outputs register the used copy
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			params_o <= '0;
		else
			params_o <= {active[0], active[1], active[2], active[3],
				active[4], active[5]};
	end

	// a new direction needs fresh encoder learning; set beats clear
	wire dir_change = do_write && (widx == 3'h3)
		&& (wr_val[15:0] != bank[3]);
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			run_inhibit_o <= 1'b0;
		else if (dir_change)
			run_inhibit_o <= 1'b1;
		else if (encoder_learned_i)
			run_inhibit_o <= 1'b0;
	end

	// ************************************************************
	// reply
	// ************************************************************

	// both replies are the first six request bytes plus a new crc
	wire [15:0] tx_crc_next = (tx_idx < `MBDW_REPLY_HDR)
		? crc_step(tx_crc, tx_o.data) : tx_crc;
	wire [2:0] tx_idx_next = tx_idx + 3'h1;
	wire [7:0] tx_sel = (tx_idx_next < `MBDW_REPLY_HDR)
		? rx_buf[tx_idx_next]
		: (tx_idx_next == `MBDW_REPLY_HDR) ? tx_crc_next[7:0]
		: tx_crc_next[15:8];
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			tx_o <= '0;
			tx_idx <= 3'h0;
			tx_crc <= `MBDW_CRC_INIT;
		end
		else if (do_write)
		begin
			tx_o <= '{valid: 1'b1, data: rx_buf[0]};
			tx_idx <= 3'h0;
			tx_crc <= `MBDW_CRC_INIT;
		end
		else if (tx_fire)
		begin
			tx_o <= '{valid: (tx_idx != 3'h7), data: tx_sel};
			tx_idx <= tx_idx_next;
			tx_crc <= tx_crc_next;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_silent_drop: assert property (in_exec && !frame_ok |=>
		state == mbdw_pkg::MBDW_ST_RX && !tx_o.valid)
		else $error("refused frame got a reply");
	a_reply_start: assert property (do_write |=>
		tx_o.valid && tx_o.data == $past(rx_buf[0]) && tx_idx == 3'h0)
		else $error("reply did not start with slave address");
	a_stop_lock: assert property (in_exec && drive_enabled_i
		&& wcls == mbdw_pkg::MBDW_SET_STOP |=> $stable(bank[widx]))
		else $error("stop-to-set parameter written while enabled");
	a_dir_block: assert property ($changed(bank[3]) |->
		run_inhibit_o)
		else $error("direction change left run enabled");
	a_word_hi_first: assert property (do_write && is_dword
		&& !word_order_select_i |=>
		bank[$past(widx)] == $past({rx_buf[9], rx_buf[10]}))
		else $error("high word first order not honoured");
	a_dir_range: assert property (bank[3] <= `MBDW_MAX_DIRECTION)
		else $error("direction outside 0..1");
	a_speed_min: assert property (bank[1] != 16'h0000
		&& bank[2] != 16'h0000 && bank[4] != 16'h0000)
		else $error("speed or pole pairs reached zero");
	a_crc_high_last: assert property (tx_fire && tx_idx == 3'h6 |=>
		tx_o.valid && tx_o.data == tx_crc[15:8]
		&& tx_idx == 3'h7)
		else $error("crc high byte not sent last");
	a_frame_end: assert property (tx_fire && tx_idx == 3'h7 |=>
		!tx_o.valid && state == mbdw_pkg::MBDW_ST_RX)
		else $error("reply longer than eight bytes");
	a_now_effect: assert property ($changed(bank[1]) |=>
		params_o.motor_rated_speed == $past(bank[1]))
		else $error("immediate parameter not in effect");

	c_dword_write: cover property (do_write && is_dword);
	c_word_write: cover property (do_write && is_word);
	c_refused: cover property (in_exec && fr_crc_ok && !set_ok);
	c_reply_done: cover property (tx_fire && tx_idx == 3'h7);

endmodule

`default_nettype wire

// ---- mbdw_master.sv ----
// Purpose: modbus master model that faces the parameter writer
// Assumes: one request in flight at a time, slave replies in order
// Notes: slow_i makes the reply sink accept every other cycle
`include "mbdw_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module mbdw_master
(
	input wire logic clk_i,
	input wire logic slow_i,
	input wire mbdw_pkg::mbdw_byte_s tx_i,
	output var mbdw_pkg::mbdw_byte_s rx_o,
	output var logic frame_end_o,
	output var logic tx_ready_o
);
	logic [7:0] got[$];

	// ****************************************************************
	// frame building and sending
	// ****************************************************************
	initial
	begin
		rx_o = '0;
		frame_end_o = 1'b0;
		tx_ready_o = 1'b1;
	end

	// reflected crc16, kept apart from the design's own code
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = `MBDW_CRC_INIT;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			repeat (8)
				c = c[0] ? ((c >> 1) ^ `MBDW_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// caller gives fields in order; crc goes low byte first
	task automatic send(input logic [7:0] q[$], input bit bad);
		logic [15:0] c;
		c = crc16(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		got.delete();
		foreach (q[i])
		begin
			@(posedge clk_i);
			rx_o <= {1'b1, q[i]};
		end
		// released data shows the inverse so stale bytes cannot match
		@(posedge clk_i);
		rx_o <= {1'b0, ~rx_o.data};
		frame_end_o <= 1'b1;
		@(posedge clk_i);
		frame_end_o <= 1'b0;
	endtask

	// reply sink, prompt or half rate
	always @(posedge clk_i)
	begin
		tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
		if (tx_i.valid && tx_ready_o)
			got.push_back(tx_i.data);
	end
endmodule

`default_nettype wire

// ---- mbdw_writer_bench.sv ----
// Purpose: self-checking bench of the parameter writer
// Assumes: slave address 1, motor group at base 0
// Notes: addresses are used unchanged, as a macro-addressing host would
`include "mbdw_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module mbdw_writer_bench;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic word_order_select_i = 1'b0;
	logic drive_enabled_i = 1'b0;
	logic password_ok_i = 1'b0;
	logic encoder_learned_i = 1'b0;
	logic slow = 1'b0;
	mbdw_pkg::mbdw_byte_s rx;
	mbdw_pkg::mbdw_byte_s tx;
	mbdw_pkg::mbdw_params_s p;
	logic frame_end;
	logic tx_ready;
	logic run_inhibit;
	int bad_count = 0;
	int checks_done = 0;

	// ****************************************************************
	// clock, instances and shared tasks
	// ****************************************************************
	always #12.5 clk_i = ~clk_i;

	mbdw_writer mbdw_writer_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.rx_i(rx), .frame_end_i(frame_end), .slave_addr_i(8'h01),
		.word_order_select_i(word_order_select_i),
		.drive_enabled_i(drive_enabled_i), .zero_speed_i(1'b0),
		.password_ok_i(password_ok_i), .drive_reset_i(1'b0),
		.encoder_learned_i(encoder_learned_i), .tx_ready_i(tx_ready),
		.tx_o(tx), .params_o(p), .run_inhibit_o(run_inhibit));

	mbdw_master mbdw_master_i (.clk_i(clk_i), .slow_i(slow), .tx_i(tx),
		.rx_o(rx), .frame_end_o(frame_end), .tx_ready_o(tx_ready));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// bounded wait for the reply, then a margin to catch extra bytes
	task automatic expect_reply(input logic [7:0] q[$]);
		int n;
		n = 0;
		while (mbdw_master_i.got.size() < q.size() && n < 60)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 60)
		begin
			bad_count++;
			$display("Error at %0t: reply timed out", $time);
			tally_and_finish();
		end
		repeat (6) @(posedge clk_i);
		cmp(16'(mbdw_master_i.got.size()), 16'(q.size()));
		foreach (q[i])
			if (i < mbdw_master_i.got.size())
				cmp({8'h00, mbdw_master_i.got[i]}, {8'h00, q[i]});
	endtask

	// double write; the reply drops byte count and data
	task automatic dword(input logic [15:0] a, input logic [31:0] v,
		input bit ok, input bit bad);
		logic [7:0] q[$];
		logic [7:0] r[$];
		logic [15:0] c;
		r = {8'h01, `MBDW_FC_WRITE_DWORD, a[15:8], a[7:0], 8'h00, 8'h02};
		q = {r, `MBDW_BYTE_COUNT};
		if (word_order_select_i)
			q = {q, v[15:8], v[7:0], v[31:24], v[23:16]};
		else
			q = {q, v[31:24], v[23:16], v[15:8], v[7:0]};
		c = mbdw_master_i.crc16(r);
		r = {r, c[7:0], c[15:8]};
		if (!ok)
			r.delete();
		mbdw_master_i.send(q, bad);
		expect_reply(r);
	endtask

	// extra edge so the next frame is built from the settled levels
	task automatic set_in(input logic wo, input logic en, input logic pw);
		@(posedge clk_i);
		word_order_select_i <= wo;
		drive_enabled_i <= en;
		password_ok_i <= pw;
		@(posedge clk_i);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_defaults();
		cmp(mbdw_master_i.crc16({8'h01, 8'h10, 8'h00, 8'h0b, 8'h00,
			8'h02, 8'h04, 8'h00, 8'h00, 8'h27, 8'h10}), 16'h20a8);
		cmp(mbdw_master_i.crc16({8'h01, 8'h10, 8'h00, 8'h0b, 8'h00,
			8'h02}), 16'h0a30);
		cmp(p.motor_rated_current, 16'h003c);
		cmp(p.motor_rated_speed, 16'h0bb8);
		cmp(p.motor_max_speed, 16'h0bb8);
		cmp(p.rotation_direction_select, 16'h0001);
		cmp(p.motor_pole_pairs, 16'h0004);
		cmp(p.motor_type_select, 16'h0000);
	endtask

	// both word orders, slow sink on the second, range edges
	task automatic t_word_order();
		dword(16'h0002, 32'h0000_7fff, 1'b1, 1'b0);
		cmp(p.motor_rated_speed, 16'h7fff);
		set_in(1'b1, 1'b0, 1'b0);
		slow <= 1'b1;
		dword(16'h0003, 32'h0000_07d0, 1'b1, 1'b0);
		cmp(p.motor_max_speed, 16'h07d0);
		slow <= 1'b0;
		set_in(1'b0, 1'b0, 1'b0);
		dword(16'h0003, 32'h0000_0000, 1'b0, 1'b0);
		cmp(p.motor_max_speed, 16'h07d0);
		dword(16'h0007, 32'h0000_0001, 1'b0, 1'b0);
	endtask

	// enabled drive, bad crc and missing password are all dropped
	task automatic t_refusals();
		set_in(1'b0, 1'b1, 1'b0);
		dword(16'h0005, 32'h0000_0007, 1'b0, 1'b0);
		cmp(p.motor_pole_pairs, 16'h0004);
		set_in(1'b0, 1'b0, 1'b0);
		dword(16'h0005, 32'h0000_0007, 1'b0, 1'b1);
		cmp(p.motor_pole_pairs, 16'h0004);
		dword(16'h0001, 32'h0000_0064, 1'b0, 1'b0);
		cmp(p.motor_rated_current, 16'h003c);
		set_in(1'b0, 1'b0, 1'b1);
		dword(16'h0001, 32'h0000_0064, 1'b1, 1'b0);
		cmp(p.motor_rated_current, 16'h0064);
	endtask

	task automatic t_direction();
		dword(16'h0004, 32'h0000_0002, 1'b0, 1'b0);
		cmp({15'h0000, run_inhibit}, 16'h0000);
		dword(16'h0004, 32'h0000_0000, 1'b1, 1'b0);
		cmp(p.rotation_direction_select, 16'h0000);
		cmp({15'h0000, run_inhibit}, 16'h0001);
		@(posedge clk_i);
		encoder_learned_i <= 1'b1;
		@(posedge clk_i);
		encoder_learned_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		cmp({15'h0000, run_inhibit}, 16'h0000);
	endtask

	// single write is echoed whole
	task automatic t_single();
		logic [7:0] q[$];
		logic [15:0] c;
		q = {8'h01, `MBDW_FC_WRITE_WORD, 8'h00, 8'h05, 8'h00, 8'h06};
		c = mbdw_master_i.crc16(q);
		mbdw_master_i.send(q, 1'b0);
		expect_reply({q, c[7:0], c[15:8]});
		cmp(p.motor_pole_pairs, 16'h0006);
	endtask

	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		// defaults appear one edge after release, seen one edge later
		repeat (2) @(posedge clk_i);
		t_defaults();
		t_word_order();
		t_refusals();
		t_direction();
		t_single();
		tally_and_finish();
	end
endmodule

`default_nettype wire
